// ===== core/sbfm_consts.svh
// Purpose: constants of the supply and boost fault manager
// Assumes: 100 MHz internal clock
// Notes:   register offsets are byte addresses on a 32-bit bus
`ifndef SBFM_CONSTS_SVH
`define SBFM_CONSTS_SVH

// timing
`define SBFM_CLK_KHZ        100000
`define SBFM_RECOVERY_MS    100
`define SBFM_BOOST_OCP_MS   110
`define SBFM_INIT_LAST      2'h3

// register offsets
`define SBFM_OFS_SUP_STATUS 8'h00
`define SBFM_OFS_BST_STATUS 8'h04
`define SBFM_OFS_SUP_ENABLE 8'h08
`define SBFM_OFS_BST_ENABLE 8'h0c
`define SBFM_OFS_STATE      8'h10

// supply fault status bits
`define SBFM_SUP_IN_UV      0
`define SBFM_SUP_IN_OV      1
`define SBFM_SUP_INT_UV     2
`define SBFM_SUP_IN_OC      3
`define SBFM_SUP_PUMP       4
`define SBFM_SUP_PUMP_CAP   5
`define SBFM_SUP_CFG_CHK    6

// boost fault status bits
`define SBFM_BST_LOW_OV     0
`define SBFM_BST_HIGH_OV    1
`define SBFM_BST_OC         2
`define SBFM_BST_STRING     3
`define SBFM_BST_MODE       4
`define SBFM_BST_FREQ       5

// reset values
`define SBFM_SUP_EN_RST     7'h7f
`define SBFM_BST_EN_RST     6'h3f

// defaults used when a strap is missing or invalid, then the addresses for low and high modes
`define SBFM_DEF_STRINGS    3'h0
`define SBFM_DEF_MODE       3'h4
`define SBFM_DEF_BOOST_FREQ 4'h0
`define SBFM_DEF_PWM_FREQ   3'h1
`define SBFM_ADDR_LOW_MODES 7'h2b
`define SBFM_ADDR_HI_MODES  7'h2a

`endif

// ===== core/sbfm_pkg.sv
// Purpose: types of the supply and boost fault manager
// Assumes: nothing
// Notes:   state codes are the default enum values, 0 to 4 in order
package sbfm_pkg;
  typedef enum logic [2:0] {
    st_init,
    st_soft_start,
    st_normal,
    st_standby,
    st_recovery
  } sbfm_state_t;
endpackage

// ===== core/sbfm_sync.sv
// Purpose: two-stage synchroniser for a bus of independent levels
// Assumes: each bit is a slow level; no word coherence is implied
// Notes:   the first stage is read by the second stage only
`timescale 1ns/1ps
module sbfm_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// ===== core/sbfm_core.sv
// Purpose: supply, charge pump, boost and strap fault manager with Wishbone registers
// Assumes: comparator and strap pins are asynchronous levels, high = condition present
// Notes:   flags are write-one-to-clear; a set in the same cycle wins
// What this block does
// - input undervoltage during operation turns boost, LEDs, FET off; go standby
// - input undervoltage sets its supply flag and raises the interrupt
// - divider pin back above rising threshold leaves standby, restarts start-up
// - input overvoltage turns outputs off, goes standby, sets flag, interrupts
// - after overvoltage, restart only once input falls below falling threshold
// - internal supply undervoltage turns outputs off, standby, flag, interrupt
// - internal supply recovered returns to active without host action
// - input overcurrent turns outputs off, sets its flag, interrupts
// - input overcurrent enters recovery, restarts 100 ms after the fault
// - boost cycle-by-cycle current limit is normal, no flag, no shutdown
// - charge pump low turns outputs off, sets flag, interrupts, retries after 100 ms
// - pump capacitor fault at init disables pump, sets both flags, recovers
// - configuration check failure sets its flag, interrupts, keeps running
// - feedback low overvoltage sets flag and holds switching, no recovery
// - low overvoltage is evaluated only in soft start or normal operation
// - high overvoltage on feedback or output pin sets flag, recovers 100 ms
// - feedback undervoltage for 110 ms sets boost overcurrent flag, recovers
// - overcurrent timer runs from boost start, including soft start
// - bad string strap uses six channels at full current, sets flag
// - bad mode strap uses phase-shift dimming at address 0x2A, sets flag
// - bad frequency strap uses 400 kHz or 305 Hz default, sets flag
// - straps are checked only at initialization; latched setup is kept
// - flags stay set until host clears them; new fault sets them again
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sbfm_consts.svh"
module sbfm_core #(
  parameter int unsigned RECOVERY_CYCLES = `SBFM_RECOVERY_MS * `SBFM_CLK_KHZ,
  parameter int unsigned OCP_CYCLES      = `SBFM_BOOST_OCP_MS * `SBFM_CLK_KHZ,
  parameter int unsigned CNT_W           = 24
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // comparator pins
  input  wire logic                input_undervoltage_divider_pin,
  input  wire logic                input_overvoltage,
  input  wire logic                internal_supply_undervoltage,
  input  wire logic                input_overcurrent,
  input  wire logic                charge_pump_low,
  input  wire logic                pump_capacitor_bad,
  input  wire logic                boost_feedback_low_ov,
  input  wire logic                boost_feedback_high_ov,
  input  wire logic                output_pin_a_ov,
  input  wire logic                boost_feedback_uv,
  input  wire logic                boost_cycle_limit,
  // strap pins
  input  wire logic [2:0]          string_config_strap,
  input  wire logic                string_config_strap_ok,
  input  wire logic [2:0]          dimming_mode_strap,
  input  wire logic                dimming_mode_strap_ok,
  input  wire logic [3:0]          boost_frequency_strap,
  input  wire logic                boost_frequency_strap_ok,
  input  wire logic [2:0]          dimming_frequency_strap,
  input  wire logic                dimming_frequency_strap_ok,
  // internal logic
  input  wire logic                config_check_fail,
  input  wire logic                soft_start_done,
  // power controls
  output logic                     power_fet_en,
  output logic                     boost_en,
  output logic                     led_en,
  output logic                     charge_pump_en,
  output logic                     boost_hold,
  output logic                     int_n,
  // latched configuration
  output logic      [2:0]          cfg_strings,
  output logic      [2:0]          cfg_mode,
  output logic      [3:0]          cfg_boost_freq,
  output logic      [2:0]          cfg_pwm_freq,
  output logic      [6:0]          i2c_addr,
  output sbfm_pkg::sbfm_state_t    dev_state
);
  import sbfm_pkg::*;

  localparam int SYNC_W = 28;

  logic [SYNC_W-1:0] pins_s;
  logic              uv, ov, vdd, oc, cp_low, cap_bad, fbl, fbh, pina, fbuv, cyc_lim;
  logic              str_ok, mode_ok, bf_ok, pf_ok;
  logic [2:0]        str, mode, pf;
  logic [3:0]        bf;

  sbfm_sync #(.W(SYNC_W)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   ({input_undervoltage_divider_pin, input_overvoltage,
             internal_supply_undervoltage, input_overcurrent, charge_pump_low,
             pump_capacitor_bad, boost_feedback_low_ov, boost_feedback_high_ov,
             output_pin_a_ov, boost_feedback_uv, boost_cycle_limit,
             string_config_strap_ok, dimming_mode_strap_ok,
             boost_frequency_strap_ok, dimming_frequency_strap_ok,
             string_config_strap, dimming_mode_strap, boost_frequency_strap,
             dimming_frequency_strap}),
    .dout  (pins_s)
  );

  assign {uv, ov, vdd, oc, cp_low, cap_bad, fbl, fbh, pina, fbuv, cyc_lim,
          str_ok, mode_ok, bf_ok, pf_ok, str, mode, bf, pf} = pins_s;

  sbfm_state_t      state, next_state;
  logic [1:0]       init_cnt;
  logic [CNT_W-1:0] rec_cnt, ocp_cnt;
  logic             cp_off;
  logic [6:0]       sup_flags, sup_en;
  logic [5:0]       bst_flags, bst_en;

  // state decode
  wire run_st    = (state == st_soft_start) || (state == st_normal);
  wire live_st   = run_st || (state == st_recovery);
  wire init_eval = (state == st_init) && (init_cnt == `SBFM_INIT_LAST);
  wire stby_any  = uv || ov || vdd;
  wire rec_done  = rec_cnt == CNT_W'(RECOVERY_CYCLES - 1);
  wire ocp_exp   = run_st && fbuv && (ocp_cnt == CNT_W'(OCP_CYCLES - 1));

  // fault events
  wire uv_ev   = live_st && uv;
  wire ov_ev   = live_st && ov;
  wire vdd_ev  = live_st && vdd;
  wire oc_ev   = run_st && oc;
  wire cp_ev   = run_st && cp_low;
  wire cap_ev  = init_eval && cap_bad;
  wire crc_ev  = init_eval && config_check_fail;
  wire ovpl_ev = run_st && fbl;
  wire ovph_ev = run_st && (fbh || pina);
  wire rec_flt = oc_ev || cp_ev || ovph_ev || ocp_exp;

  // wishbone decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr      = bus_req && wb_we_i;
  wire hit_ss  = wb_adr_i == `SBFM_OFS_SUP_STATUS;
  wire hit_bs  = wb_adr_i == `SBFM_OFS_BST_STATUS;
  wire hit_se  = wb_adr_i == `SBFM_OFS_SUP_ENABLE;
  wire hit_be  = wb_adr_i == `SBFM_OFS_BST_ENABLE;
  wire hit_st  = wb_adr_i == `SBFM_OFS_STATE;

  wire [6:0] sup_clr = (wr && hit_ss && wb_sel_i[0]) ? wb_dat_i[6:0] : 7'h00;
  wire [5:0] bst_clr = (wr && hit_bs && wb_sel_i[0]) ? wb_dat_i[5:0] : 6'h00;

  wire [6:0] sup_set = {crc_ev, cap_ev, cp_ev || cap_ev, oc_ev, vdd_ev, ov_ev, uv_ev};
  wire [5:0] bst_set = {init_eval && !(bf_ok && pf_ok), init_eval && !mode_ok,
                        init_eval && !str_ok, ocp_exp, ovph_ev, ovpl_ev};

  // a fresh event beats a host clear in the same cycle
  wire [6:0] next_sup = (sup_flags & ~sup_clr) | sup_set;
  wire [5:0] next_bst = (bst_flags & ~bst_clr) | bst_set;

  wire [31:0] rd_data =
      hit_ss ? {25'h0, sup_flags} :
      hit_bs ? {26'h0, bst_flags} :
      hit_se ? {25'h0, sup_en} :
      hit_be ? {26'h0, bst_en} :
      hit_st ? {13'h0, cfg_pwm_freq, cfg_boost_freq, 1'b0, cfg_mode,
                1'b0, cfg_strings, boost_hold, state} :
      32'h00000000;

  // recovery timer restarts on every entry into recovery
  wire [CNT_W-1:0] next_rec = (state == st_recovery && next_state == st_recovery) ?
                              rec_cnt + 1'b1 : '0;
  // overcurrent timer: counts from boost start while feedback stays low
  wire [CNT_W-1:0] next_ocp = (run_st && fbuv && !ocp_exp) ? ocp_cnt + 1'b1 : '0;

  wire run_nx      = (next_state == st_soft_start) || (next_state == st_normal);
  wire next_cp_off = cap_ev || (cp_off && next_state == st_recovery);

  always_comb begin
    next_state = state;
    unique case (state)
      st_init: begin
        if (init_eval) begin
          next_state = cap_bad ? st_recovery : st_soft_start;
        end
      end
      st_soft_start: begin
        if (stby_any) begin
          next_state = st_standby;
        end else if (rec_flt) begin
          next_state = st_recovery;
        end else if (soft_start_done) begin
          next_state = st_normal;
        end
      end
      st_normal: begin
        if (stby_any) begin
          next_state = st_standby;
        end else if (rec_flt) begin
          next_state = st_recovery;
        end
      end
      st_standby: begin
        if (!stby_any) begin
          next_state = st_soft_start;
        end
      end
      st_recovery: begin
        if (stby_any) begin
          next_state = st_standby;
        end else if (rec_done) begin
          next_state = st_soft_start;
        end
      end
      default: begin
        next_state = st_init;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= st_init;
      init_cnt <= 2'h0;
      rec_cnt  <= '0;
      ocp_cnt  <= '0;
      cp_off   <= 1'b0;
    end else begin
      state    <= next_state;
      init_cnt <= (state == st_init) ? init_cnt + 2'h1 : 2'h0;
      rec_cnt  <= next_rec;
      ocp_cnt  <= next_ocp;
      cp_off   <= next_cp_off;
    end
  end

  // power controls come from the next state so they drop with the transition
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_fet_en   <= 1'b0;
      boost_en       <= 1'b0;
      led_en         <= 1'b0;
      charge_pump_en <= 1'b0;
      boost_hold     <= 1'b0;
    end else begin
      power_fet_en   <= run_nx;
      boost_en       <= run_nx;
      led_en         <= run_nx;
      charge_pump_en <= !next_cp_off;
      boost_hold     <= run_nx && fbl;
    end
  end

  // straps are sampled once; later strap changes are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_strings    <= `SBFM_DEF_STRINGS;
      cfg_mode       <= `SBFM_DEF_MODE;
      cfg_boost_freq <= `SBFM_DEF_BOOST_FREQ;
      cfg_pwm_freq   <= `SBFM_DEF_PWM_FREQ;
      i2c_addr       <= `SBFM_ADDR_HI_MODES;
    end else if (init_eval) begin
      cfg_strings    <= str_ok ? str : `SBFM_DEF_STRINGS;
      cfg_mode       <= mode_ok ? mode : `SBFM_DEF_MODE;
      cfg_boost_freq <= bf_ok ? bf : `SBFM_DEF_BOOST_FREQ;
      cfg_pwm_freq   <= pf_ok ? pf : `SBFM_DEF_PWM_FREQ;
      i2c_addr       <= (mode_ok && !mode[2]) ? `SBFM_ADDR_LOW_MODES :
                                                `SBFM_ADDR_HI_MODES;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sup_flags <= 7'h00;
      bst_flags <= 6'h00;
      sup_en    <= `SBFM_SUP_EN_RST;
      bst_en    <= `SBFM_BST_EN_RST;
      int_n     <= 1'b1;
    end else begin
      sup_flags <= next_sup;
      bst_flags <= next_bst;
      if (wr && hit_se && wb_sel_i[0]) begin
        sup_en <= wb_dat_i[6:0];
      end
      if (wr && hit_be && wb_sel_i[0]) begin
        bst_en <= wb_dat_i[5:0];
      end
      int_n <= !(|(sup_flags & sup_en) || |(bst_flags & bst_en));
    end
  end

  // one wait state; unmapped addresses answer with zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_state <= st_init;
    end else begin
      dev_state <= next_state;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  wire other_flt = stby_any || rec_flt || fbl;

  a_uv_standby: assert property (uv_ev |=> state == st_standby && !boost_en)
    else $error("undervoltage did not reach standby");
  a_uv_int: assert property (uv_ev && sup_en[0] |=> ##1 !int_n)
    else $error("undervoltage did not raise interrupt");
  a_standby_exit: assert property (state == st_standby && !stby_any |=> state == st_soft_start)
    else $error("standby not left after supply recovered");
  a_ov_hold: assert property (state == st_standby && ov |=> state == st_standby)
    else $error("left standby while overvoltage present");
  a_ov_off: assert property (ov_ev |=> !power_fet_en && !led_en && sup_flags[1])
    else $error("overvoltage left outputs on");
  a_vdd_auto: assert property (vdd_ev ##1 !stby_any |=> state == st_soft_start)
    else $error("no automatic restart after internal supply");
  a_oc_recover: assert property (oc_ev && !stby_any |=> state == st_recovery && !boost_en)
    else $error("overcurrent did not enter recovery");
  a_rec_length: assert property (state == st_recovery && !stby_any && !rec_done
                                 |=> state == st_recovery)
    else $error("recovery left early");
  a_rec_end: assert property (state == st_recovery && rec_done && !stby_any
                              |=> state == st_soft_start)
    else $error("recovery overran");
  a_limit_benign: assert property (state == st_normal && cyc_lim && !other_flt
                                   |=> state == st_normal && $stable(bst_flags))
    else $error("cycle limit disturbed operation");
  a_cap_pump: assert property (cap_ev |=> sup_flags[5] && sup_flags[4] && !charge_pump_en)
    else $error("pump capacitor fault mishandled");
  a_lowov_hold: assert property (!run_st |-> !boost_hold)
    else $error("low overvoltage acted outside run");
  a_ocp_fire: assert property (ocp_exp && !stby_any |=> state == st_recovery && bst_flags[2])
    else $error("boost overcurrent timer did not fire");
  a_cfg_stable: assert property (state != st_init |=> $stable(cfg_strings) && $stable(cfg_mode))
    else $error("configuration changed after init");
  a_flag_sticky: assert property (sup_flags[0] && !sup_clr[0] |=> sup_flags[0])
    else $error("flag lost without clear");
  a_int_clear: assert property ((sup_flags & sup_en) == 7'h00 && (bst_flags & bst_en) == 6'h00
                                |=> int_n)
    else $error("interrupt stuck with no enabled flag");

  c_uv_cycle: cover property (uv_ev ##[1:50] state == st_soft_start);
  c_recovery: cover property (state == st_recovery ##1 state == st_soft_start);
  c_strap_bad: cover property (init_eval && !str_ok);
  c_clear_ack: cover property (wr && hit_ss ##1 wb_ack_o);
endmodule

// ===== tb/sbfm_host.sv
// Purpose: host model that reads and clears fault flags over Wishbone
// Assumes: classic single cycles, one request outstanding
// Notes:   int_n is watched by the bench, not by this model
`timescale 1ns/1ps
`include "sbfm_consts.svh"
module sbfm_host (
  // clock
  input  wire logic        clk,
  // wishbone master
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [31:0]      dat_w,
  output logic [3:0]       sel,
  input  wire logic [31:0] dat_r,
  input  wire logic        ack
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat_w = 32'h0;
    sel = 4'h0;
  end
  // request held until ack is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic clear_all();
    logic [31:0] q;
    xfer(1'b1, `SBFM_OFS_SUP_STATUS, 32'h7f, q);
    xfer(1'b1, `SBFM_OFS_BST_STATUS, 32'h3f, q);
  endtask
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the supply and boost fault manager
// Assumes: short recovery and overcurrent counts set by parameter
// Notes:   all inputs move by non-blocking assignment at rising edges
`timescale 1ns/1ps
`include "sbfm_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module tb_top;
  import sbfm_pkg::*;
  localparam int REC_C = 20;
  localparam int OCP_C = 30;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc, stb, we, ack, pfet, ben, len, cpen, hold, int_n;
  logic [7:0]  adr;
  logic [31:0] dw, dr, q;
  logic [3:0]  sel;
  logic [2:0]  sb = 3'h0;
  logic [3:0]  rf = 4'h0;
  logic        cap = 1'b0, low_ov = 1'b0, fb_uv = 1'b0, cyc_lim = 1'b0;
  logic        cfg_fail = 1'b1, ss_done = 1'b1;
  logic [2:0]  s_str = 3'h0, s_mode = 3'h0, s_pwm = 3'h0, c_str, c_mode, c_pwm;
  logic [3:0]  s_bf = 4'h0, s_ok = 4'h0, c_bf;
  logic [6:0]  addr;
  logic [19:0] ecfg;
  sbfm_state_t st;
  int          fails = 0, n_compared = 0, cycles = 0, n;
  integer      seed = 32'he31d;
  logic [7:0]  r_ofs [4] = '{`SBFM_OFS_SUP_STATUS, `SBFM_OFS_SUP_STATUS,
                             `SBFM_OFS_BST_STATUS, `SBFM_OFS_BST_STATUS};
  int          r_bit [4] = '{`SBFM_SUP_IN_OC, `SBFM_SUP_PUMP, `SBFM_BST_HIGH_OV,
                             `SBFM_BST_HIGH_OV};

  sbfm_core #(.RECOVERY_CYCLES(REC_C), .OCP_CYCLES(OCP_C)) dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dw), .wb_sel_i(sel), .wb_dat_o(dr), .wb_ack_o(ack),
    .input_undervoltage_divider_pin(sb[0]), .input_overvoltage(sb[1]),
    .internal_supply_undervoltage(sb[2]), .input_overcurrent(rf[0]),
    .charge_pump_low(rf[1]), .pump_capacitor_bad(cap), .boost_feedback_low_ov(low_ov),
    .boost_feedback_high_ov(rf[2]), .output_pin_a_ov(rf[3]), .boost_feedback_uv(fb_uv),
    .boost_cycle_limit(cyc_lim), .string_config_strap(s_str),
    .string_config_strap_ok(s_ok[0]), .dimming_mode_strap(s_mode),
    .dimming_mode_strap_ok(s_ok[1]), .boost_frequency_strap(s_bf),
    .boost_frequency_strap_ok(s_ok[2]), .dimming_frequency_strap(s_pwm),
    .dimming_frequency_strap_ok(s_ok[3]), .config_check_fail(cfg_fail),
    .soft_start_done(ss_done), .power_fet_en(pfet), .boost_en(ben), .led_en(len),
    .charge_pump_en(cpen), .boost_hold(hold), .int_n(int_n), .cfg_strings(c_str),
    .cfg_mode(c_mode), .cfg_boost_freq(c_bf), .cfg_pwm_freq(c_pwm), .i2c_addr(addr),
    .dev_state(st));
  sbfm_host host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat_w(dw),
                  .sel(sel), .dat_r(dr), .ack(ack));

  always #5 clk = ~clk;
  // bound sized from the whole sequence with ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end

  function automatic logic [19:0] cfg_exp();
    cfg_exp = {s_ok[0] ? s_str : `SBFM_DEF_STRINGS, s_ok[1] ? s_mode : `SBFM_DEF_MODE,
               s_ok[2] ? s_bf : `SBFM_DEF_BOOST_FREQ, s_ok[3] ? s_pwm : `SBFM_DEF_PWM_FREQ,
               (s_ok[1] && s_mode < 3'h4) ? `SBFM_ADDR_LOW_MODES : `SBFM_ADDR_HI_MODES};
  endfunction
  function automatic logic [31:0] strap_flags();
    strap_flags = 32'h0;
    strap_flags[`SBFM_BST_STRING] = !s_ok[0];
    strap_flags[`SBFM_BST_MODE] = !s_ok[1];
    strap_flags[`SBFM_BST_FREQ] = !(s_ok[2] && s_ok[3]);
  endfunction
  function automatic logic [31:0] state_exp(input logic [19:0] c, input sbfm_state_t s);
    state_exp = {13'h0, c[9:7], c[13:10], 1'b0, c[16:14], 1'b0, c[19:17], 1'b0, s};
  endfunction
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wait_st(input sbfm_state_t s, input int lim);
    n = 0;
    while (st !== s && n < lim) begin
      @(posedge clk);
      n++;
    end
    `CHK("state", s, st)
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    tick(10);
    rst_n <= 1'b1;
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    do_reset();
    wait_st(st_normal, 20);
    `CHK("cfg", cfg_exp(), {c_str, c_mode, c_bf, c_pwm, addr})
    rd(`SBFM_OFS_BST_STATUS);
    `CHK("strap flags", strap_flags(), q)
    rd(`SBFM_OFS_SUP_STATUS);
    `CHK("cfg flag", 32'h1 << `SBFM_SUP_CFG_CHK, q)
    `CHK("int", 1'b0, int_n)
    rd(`SBFM_OFS_SUP_ENABLE);
    `CHK("sup en", `SBFM_SUP_EN_RST, q)
    rd(8'h20);
    `CHK("unmapped", 32'h0, q)
    host.clear_all();
    tick(3);
    `CHK("int clr", 1'b1, int_n)
    s_str <= $random(seed);
    s_mode <= $random(seed);
    s_bf <= $random(seed);
    s_pwm <= $random(seed);
    s_ok <= $random(seed);
    cfg_fail <= 1'b0;
    do_reset();
    wait_st(st_normal, 20);
    ecfg = cfg_exp();
    `CHK("cfg", ecfg, {c_str, c_mode, c_bf, c_pwm, addr})
    s_mode <= ~s_mode;
    s_ok <= ~s_ok;
    tick(6);
    `CHK("cfg kept", ecfg, {c_str, c_mode, c_bf, c_pwm, addr})
    rd(`SBFM_OFS_STATE);
    `CHK("state reg", state_exp(ecfg, st_normal), q)
    host.clear_all();
    for (int i = 0; i < 3; i++) begin
      sb[i] <= 1'b1;
      wait_st(st_standby, 10);
      `CHK("pwr off", 3'h0, {pfet, ben, len})
      tick(2);
      `CHK("int", 1'b0, int_n)
      rd(`SBFM_OFS_SUP_STATUS);
      `CHK("sup flag", 32'h1 << i, q)
      sb[i] <= 1'b0;
      wait_st(st_normal, 12);
      `CHK("pwr on", 4'hf, {pfet, ben, len, cpen})
      host.clear_all();
      tick(3);
      `CHK("int clr", 1'b1, int_n)
    end
    for (int j = 0; j < 4; j++) begin
      rf[j] <= 1'b1;
      tick(3);
      rf[j] <= 1'b0;
      wait_st(st_recovery, 10);
      `CHK("pwr off", 3'h0, {pfet, ben, len})
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (st === st_recovery);
      `CHK("retry time", REC_C, n)
      `CHK("int", 1'b0, int_n)
      rd(r_ofs[j]);
      `CHK("rec flag", 32'h1 << r_bit[j], q)
      host.clear_all();
      wait_st(st_normal, 10);
    end
    host.xfer(1'b1, `SBFM_OFS_SUP_ENABLE, 32'h0, q);
    rf[0] <= 1'b1;
    tick(3);
    rf[0] <= 1'b0;
    tick(6);
    `CHK("int masked", 1'b1, int_n)
    host.xfer(1'b1, `SBFM_OFS_SUP_ENABLE, 32'h7f, q);
    tick(2);
    `CHK("int unmasked", 1'b0, int_n)
    wait_st(st_normal, 40);
    host.clear_all();
    fb_uv <= 1'b1;
    tick(OCP_C - 10);
    fb_uv <= 1'b0;
    tick(5);
    `CHK("no ocp", st_normal, st)
    fb_uv <= 1'b1;
    n = 0;
    while (st !== st_recovery && n < 100) begin
      @(posedge clk);
      n++;
    end
    ss_done <= 1'b0;
    `CHK("ocp time", 1'b1, n >= OCP_C && n <= OCP_C + 5)
    rd(`SBFM_OFS_BST_STATUS);
    `CHK("ocp flag", 32'h1 << `SBFM_BST_OC, q)
    host.clear_all();
    // feedback stays low, so the timer must fire again inside soft start
    wait_st(st_soft_start, 40);
    wait_st(st_recovery, OCP_C + 5);
    fb_uv <= 1'b0;
    ss_done <= 1'b1;
    rd(`SBFM_OFS_BST_STATUS);
    `CHK("ocp start flag", 32'h1 << `SBFM_BST_OC, q)
    host.clear_all();
    wait_st(st_normal, 40);
    low_ov <= 1'b1;
    tick(5);
    `CHK("hold", 1'b1, hold)
    `CHK("no recovery", st_normal, st)
    low_ov <= 1'b0;
    tick(4);
    rd(`SBFM_OFS_BST_STATUS);
    `CHK("low ov flag", 32'h1 << `SBFM_BST_LOW_OV, q)
    host.clear_all();
    repeat (40) begin
      @(posedge clk);
      cyc_lim <= $random(seed);
    end
    tick(3);
    rd(`SBFM_OFS_SUP_STATUS);
    `CHK("limit sup", 32'h0, q)
    `CHK("limit state", st_normal, st)
    `CHK("limit int", 1'b1, int_n)
    rd(`SBFM_OFS_BST_STATUS);
    `CHK("limit bst", 32'h0, q)
    cap <= 1'b1;
    do_reset();
    wait_st(st_recovery, 20);
    `CHK("pump off", 1'b0, cpen)
    rd(`SBFM_OFS_SUP_STATUS);
    `CHK("cap flags", (32'h1 << `SBFM_SUP_PUMP) | (32'h1 << `SBFM_SUP_PUMP_CAP), q)
    final_report();
  end
endmodule
